// ==== shared/qrpf_params.svh ====
// offsets, field positions, codes and reset values of the quadlet receive formatter
// assumes inclusion by bare name from design and bench files
`ifndef QRPF_PARAMS_SVH
`define QRPF_PARAMS_SVH

// register byte offsets
`define QR_OFS_CTRL       4'h0
`define QR_OFS_STATUS     4'h4
`define QR_OFS_RXFIFO     4'h8

// control register
`define QR_CTRL_EN_BIT    0
`define QR_CTRL_RESET     1'h1

// status register fields
`define QR_ST_NEMPTY_BIT  0
`define QR_ST_BUSY_BIT    1
`define QR_ST_CNT_HI      15
`define QR_ST_CNT_LO      8

// token field positions
`define QR_TK_PACKET_COMPLETE_FLAG_BIT   20
`define QR_TK_SPD_HI      18
`define QR_TK_SPD_LO      17
`define QR_TK_CNT_HI      15
`define QR_TK_CNT_LO      12
`define QR_TK_TCODE_HI    7
`define QR_TK_TCODE_LO    4
`define QR_TK_ACK_HI      3
`define QR_TK_ACK_LO      0

// transaction codes
`define QR_TC_WR_QUAD     4'h0
`define QR_TC_WR_RESP     4'h2
`define QR_TC_RD_QUAD     4'h4
`define QR_TC_RD_RESP_Q   4'h6
`define QR_TC_LOCK_RESP   4'hb

// speed codes
`define QR_SPD_100        2'h0
`define QR_SPD_200        2'h1
`define QR_SPD_400        2'h2

// data quadlet counts and fixed flags
`define QR_CNT_ONE        4'h1
`define QR_CNT_NONE       4'h0
`define QR_PACKET_COMPLETE_FLAG_LAST     1'h1
`define QR_RCODE_MASK     16'hf000

`endif

// ==== shared/qrpf_pkg.sv ====
// types of the quadlet receive formatter
// assumes the params header on the include path
package qrpf_pkg;

   typedef struct packed {
      logic [9:0] bus;
      logic [5:0] node;
   } node_id_t;

   typedef struct packed {
      logic [1:0]  spd;
      logic [3:0]  ack;
      node_id_t    dest_id;
      logic [5:0]  tlabel;
      logic [1:0]  rt;
      logic [3:0]  tcode;
      logic [3:0]  prio;
      node_id_t    src_id;
      logic [15:0] offset_high;
      logic [31:0] offset_low;
      logic [31:0] data;
   } rx_packet_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_TOKEN,
      ST_DEST,
      ST_SRC,
      ST_OFFL,
      ST_DATA
   } state_t;

endpackage

// ==== src/quadlet_receive_packet_formatter.sv ====
// receive formatter: turns a received quadlet packet into fifo quadlets
// assumes one packet per handshake from the link receiver, host on avalon-mm
`timescale 1ns/1ps
`include "qrpf_params.svh"

module quadlet_receive_packet_formatter
   import qrpf_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire rx_packet_t  i_pkt,
   input  wire logic        i_pkt_valid,
   output      logic        o_pkt_ready,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output      logic [31:0] o_avs_readdata,
   output      logic        o_avs_waitrequest
);

   state_t      state;
   state_t      next_state;
   rx_packet_t  pkt;
   logic        ctrl_en;
   logic [7:0]  pkt_cnt;

   // two-entry buffer
   logic [31:0] buf_mem [0:1];
   logic        wr_ptr;
   logic        rd_ptr;
   logic [1:0]  buf_cnt;

   // bus slave state
   logic        resp_q;
   logic        pop_ok_q;

   wire logic        accept;
   wire logic        has_data;
   wire logic        is_lock_resp;
   wire logic        buf_in_ready;
   wire logic        buf_out_valid;
   wire logic        push;
   wire logic        pop;
   wire logic [31:0] push_word;
   wire logic [31:0] token_word;
   wire logic [31:0] dest_word;
   wire logic [31:0] src_word;
   wire logic [15:0] off_high;
   wire logic [3:0]  data_count;
   wire logic        bus_req;
   wire logic        bus_take;
   wire logic        sel_ctrl;
   wire logic        sel_status;
   wire logic        sel_fifo;
   wire logic [31:0] status_word;
   wire logic [31:0] rd_mux;

   assign o_pkt_ready = (state == ST_IDLE) && ctrl_en;
   assign accept      = i_pkt_valid && o_pkt_ready;

   // payload only for write request and read response
   assign has_data = (pkt.tcode == `QR_TC_WR_QUAD) ||
                     (pkt.tcode == `QR_TC_RD_RESP_Q);
   // data quadlet count
   assign data_count = has_data ? `QR_CNT_ONE : `QR_CNT_NONE;

   assign token_word[31:`QR_TK_PACKET_COMPLETE_FLAG_BIT+1] = '0;
   assign token_word[`QR_TK_PACKET_COMPLETE_FLAG_BIT] = `QR_PACKET_COMPLETE_FLAG_LAST;
   assign token_word[`QR_TK_PACKET_COMPLETE_FLAG_BIT-1:`QR_TK_SPD_HI+1] = '0;
   assign token_word[`QR_TK_SPD_HI:`QR_TK_SPD_LO] = pkt.spd;
   assign token_word[`QR_TK_SPD_LO-1:`QR_TK_CNT_HI+1] = '0;
   assign token_word[`QR_TK_CNT_HI:`QR_TK_CNT_LO] = data_count;
   assign token_word[`QR_TK_CNT_LO-1:`QR_TK_TCODE_HI+1] = '0;
   assign token_word[`QR_TK_TCODE_HI:`QR_TK_TCODE_LO] = pkt.tcode;
   assign token_word[`QR_TK_ACK_HI:`QR_TK_ACK_LO] = pkt.ack;

   assign dest_word = {pkt.dest_id.bus, pkt.dest_id.node, pkt.tlabel,
                       pkt.rt, pkt.tcode, pkt.prio};

   assign is_lock_resp = (pkt.tcode == `QR_TC_LOCK_RESP);
   assign off_high = is_lock_resp ? (pkt.offset_high & `QR_RCODE_MASK)
                                  : pkt.offset_high;

   assign src_word = {pkt.src_id, off_high};

   assign push_word = (state == ST_TOKEN) ? token_word :
                      (state == ST_DEST)  ? dest_word  :
                      (state == ST_SRC)   ? src_word   :
                      (state == ST_OFFL)  ? pkt.offset_low :
                      pkt.data;

   assign push = (state != ST_IDLE) && buf_in_ready;

   // sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (accept)
               next_state = ST_TOKEN;
         ST_TOKEN:
            if (push)
               next_state = ST_DEST;
         ST_DEST:
            if (push)
               next_state = ST_SRC;
         ST_SRC:
            if (push)
               next_state = ST_OFFL;
         ST_OFFL:
            if (push)
               next_state = has_data ? ST_DATA : ST_IDLE;
         ST_DATA:
            if (push)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state <= ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pkt <= '0;
      else if (accept)
         pkt <= i_pkt;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         pkt_cnt <= '0;
      else if (accept)
         pkt_cnt <= pkt_cnt + 8'h01;
   end

   // two-entry buffer
   assign buf_in_ready  = (buf_cnt != 2'h2);
   assign buf_out_valid = (buf_cnt != 2'h0);

   always_ff @(posedge i_clk)
   begin
      if (push)
         buf_mem[wr_ptr] <= push_word;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr  <= 1'b0;
         rd_ptr  <= 1'b0;
         buf_cnt <= 2'h0;
      end
      else
      begin
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
         if (push && !pop)
            buf_cnt <= buf_cnt + 2'h1;
         else if (pop && !push)
            buf_cnt <= buf_cnt - 2'h1;
      end
   end

   // avalon slave: one wait cycle per access
   assign bus_req  = i_avs_read || i_avs_write;
   assign bus_take = bus_req && resp_q;
   assign o_avs_waitrequest = bus_req && !resp_q;

   assign sel_ctrl   = (i_avs_address == `QR_OFS_CTRL);
   assign sel_status = (i_avs_address == `QR_OFS_STATUS);
   assign sel_fifo   = (i_avs_address == `QR_OFS_RXFIFO);

   assign status_word = {16'h0000, pkt_cnt, 6'h00,
                         (state != ST_IDLE), buf_out_valid};

   assign rd_mux = sel_ctrl   ? {31'h0, ctrl_en} :
                   sel_status ? status_word :
                   (sel_fifo && buf_out_valid) ? buf_mem[rd_ptr] :
                   32'h0000_0000;

   assign pop = bus_take && i_avs_read && sel_fifo && pop_ok_q;

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         resp_q <= 1'b0;
      else
         resp_q <= bus_req && !resp_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_avs_readdata <= '0;
         pop_ok_q       <= 1'b0;
      end
      else if (i_avs_read && !resp_q)
      begin
         o_avs_readdata <= rd_mux;
         pop_ok_q       <= sel_fifo && buf_out_valid;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ctrl_en <= `QR_CTRL_RESET;
      else if (bus_take && i_avs_write && sel_ctrl && i_avs_byteenable[0])
         ctrl_en <= i_avs_writedata[`QR_CTRL_EN_BIT];
   end

   AST_TOKEN_FIRST:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      accept |=> (state == ST_TOKEN) && $stable(buf_cnt) || pop)
      else $error("token not first after accept");

   AST_TOKEN_COUNT:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_TOKEN) |->
      push_word[`QR_TK_CNT_HI:`QR_TK_CNT_LO] ==
      ((pkt.tcode == `QR_TC_WR_QUAD || pkt.tcode == `QR_TC_RD_RESP_Q)
       ? 4'h1 : 4'h0))
      else $error("token count wrong");

   AST_TOKEN_PACKET_COMPLETE_FLAG:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_TOKEN) |-> push_word[`QR_TK_PACKET_COMPLETE_FLAG_BIT])
      else $error("packet complete flag clear");

   AST_TOKEN_SPD_ACK:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_TOKEN) |->
      push_word[`QR_TK_SPD_HI:`QR_TK_SPD_LO] == pkt.spd &&
      push_word[`QR_TK_ACK_HI:`QR_TK_ACK_LO] == pkt.ack)
      else $error("token speed or ack wrong");

   AST_TOKEN_RESERVED:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_TOKEN) |-> push_word[31:21] == 11'h000 &&
      push_word[19] == 1'b0 && push_word[16] == 1'b0 && push_word[11:8] == 4'h0)
      else $error("token reserved bits set");

   AST_CAPTURE_ACK:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      accept |=> pkt.ack == $past(i_pkt.ack) && pkt.spd == $past(i_pkt.spd))
      else $error("returned ack code not captured");

   AST_LABEL_KEEP:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      accept |=> pkt.tlabel == $past(i_pkt.tlabel) && pkt.rt == $past(i_pkt.rt))
      else $error("transaction label altered");

   AST_RETRY_POS:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_DEST) |-> push_word[9:8] == pkt.rt && push_word[3:0] == pkt.prio)
      else $error("retry code misplaced");

   AST_SRC_KEEP:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      accept |=> pkt.src_id == $past(i_pkt.src_id))
      else $error("source id not captured");

   AST_TCODE_BOTH:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_TOKEN) |=>
      (state == ST_DEST) && dest_word[7:4] == $past(push_word[7:4]))
      else $error("tcode mismatch token header");

   AST_DEST_POS:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_DEST) |->
      push_word[31:16] == pkt.dest_id && push_word[15:10] == pkt.tlabel)
      else $error("destination quadlet wrong");

   AST_SRC_POS:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_SRC) |-> push_word[31:16] == pkt.src_id)
      else $error("source quadlet wrong");

   AST_OFF_LOW:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_OFFL) |-> push_word == pkt.offset_low)
      else $error("offset low quadlet wrong");

   AST_OFF_HIGH:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_SRC) && !is_lock_resp |-> push_word[15:0] == pkt.offset_high)
      else $error("offset high half wrong");

   AST_DATA_FIFTH:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_DATA) |-> has_data && push_word == pkt.data)
      else $error("fifth quadlet wrong");

   AST_NO_FIFTH:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_OFFL) && !has_data |=> (state == ST_IDLE))
      else $error("fifth quadlet without payload");

   AST_LOCK_RCODE:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      push && (state == ST_SRC) && is_lock_resp |-> push_word[11:0] == 12'h000)
      else $error("lock response reserved bits set");

   // never push into a full buffer
   AST_NO_OVERFLOW:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (buf_cnt == 2'h2) && !pop |=> (buf_cnt == 2'h2))
      else $error("buffer lost a quadlet");

   AST_POP_NONEMPTY:
   assert property (@(posedge i_clk) disable iff (!i_rst_n)
      pop |-> buf_out_valid)
      else $error("pop from empty buffer");

endmodule

// ==== sim/host_fifo_reader.sv ====
// host side model: avalon-mm master that performs one access per request
// assumes requests are raised only while the model is idle
`timescale 1ns/1ps

module host_fifo_reader
   import qrpf_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   output      logic        o_done,
   output      logic [31:0] o_rdata,
   output      logic        o_read,
   output      logic        o_write,
   output      logic [3:0]  o_address,
   output      logic [31:0] o_writedata,
   output      logic [3:0]  o_byteenable,
   input  wire logic [31:0] i_readdata,
   input  wire logic        i_waitrequest
);
   wire busy = o_read | o_write;
   assign o_byteenable = 4'hf;

   // hold request until waitrequest low, then release and scramble lines
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_read <= 1'b0;
         o_write <= 1'b0;
         o_address <= 4'h0;
         o_writedata <= 32'h0;
         o_done <= 1'b0;
         o_rdata <= 32'h0;
      end
      else
      begin
         o_done <= 1'b0;
         if (busy && !i_waitrequest)
         begin
            o_read <= 1'b0;
            o_write <= 1'b0;
            o_done <= 1'b1;
            o_rdata <= i_readdata;
            o_address <= ~o_address;
            o_writedata <= ~o_writedata;
         end
         else if (!busy && i_req)
         begin
            o_read <= !i_we;
            o_write <= i_we;
            o_address <= i_addr;
            o_writedata <= i_wdata;
         end
      end
   end
endmodule

// ==== sim/quadlet_receive_packet_formatter_tb.sv ====
// bench: offers packets, reads the receive fifo through the host model
// assumes 100 mhz clock, async active-low reset
`timescale 1ns/1ps
`include "qrpf_params.svh"

module quadlet_receive_packet_formatter_tb;
   import qrpf_pkg::*;
   logic        i_clk = 1'b0;
   logic        i_rst_n = 1'b0;
   rx_packet_t  pkt = '0;
   logic        pkt_valid = 1'b0;
   logic        req = 1'b0;
   logic        we = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        done, pkt_ready, rd, wr, wait_req;
   logic [31:0] rdata, readdata, wr_data;
   logic [3:0]  address, byte_en;
   int          error_cnt = 0;
   int          total_checks = 0;

   always #5 i_clk = ~i_clk;

   quadlet_receive_packet_formatter uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pkt(pkt),
      .i_pkt_valid(pkt_valid), .o_pkt_ready(pkt_ready), .i_avs_address(address),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wr_data),
      .i_avs_byteenable(byte_en), .o_avs_readdata(readdata), .o_avs_waitrequest(wait_req));

   host_fifo_reader host (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req), .i_we(we),
      .i_addr(addr), .i_wdata(wdata), .o_done(done), .o_rdata(rdata), .o_read(rd),
      .o_write(wr), .o_address(address), .o_writedata(wr_data), .o_byteenable(byte_en),
      .i_readdata(readdata), .i_waitrequest(wait_req));

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      req <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge i_clk);
      req <= 1'b0;
      while (n < 50)
      begin
         @(negedge i_clk);
         if (done === 1'b1)
            break;
         n++;
      end
      r = rdata;
      if (n >= 50)
      begin
         chk_bit(1'b0, 1'b1);
         summarize();
      end
      @(posedge i_clk);
   endtask

   task automatic send_pkt(input rx_packet_t p);
      int n;
      n = 0;
      pkt <= p;
      pkt_valid <= 1'b1;
      while (n < 100)
      begin
         @(negedge i_clk);
         if (pkt_ready === 1'b1)
            break;
         n++;
      end
      if (n >= 100)
      begin
         chk_bit(1'b0, 1'b1);
         summarize();
      end
      @(posedge i_clk);
      pkt_valid <= 1'b0;
      pkt <= ~p;
   endtask

   task automatic reg_access();
      logic [31:0] r;
      bus(1'b0, `QR_OFS_CTRL, 32'h0, r);
      chk(r, 32'h1);
      bus(1'b0, `QR_OFS_STATUS, 32'h0, r);
      chk(r, 32'h0);
      bus(1'b1, 4'hc, 32'hffff_ffff, r);
      bus(1'b0, 4'hc, 32'h0, r);
      chk(r, 32'h0);
      bus(1'b0, `QR_OFS_RXFIFO, 32'h0, r);
      chk(r, 32'h0);
      bus(1'b1, `QR_OFS_CTRL, 32'h0, r);
      @(negedge i_clk);
      chk_bit(pkt_ready, 1'b0);
      @(posedge i_clk);
      bus(1'b1, `QR_OFS_CTRL, 32'h1, r);
      @(negedge i_clk);
      chk_bit(pkt_ready, 1'b1);
      @(posedge i_clk);
   endtask

   task automatic run_formats();
      logic [3:0]  tc [5] = '{4'h0, 4'h4, 4'h6, 4'h2, 4'hb};
      logic [1:0]  sp [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1};
      logic [3:0]  ak [5] = '{4'h1, 4'h2, 4'h4, 4'h6, 4'h1};
      int          gap [5] = '{0, 5, 0, 3, 0};
      rx_packet_t  p;
      logic [31:0] q [6];
      logic [31:0] e [6];
      logic [31:0] r;
      logic        has;
      for (int k = 0; k < 5; k++)
      begin
         p = '0;
         p.spd = sp[k];
         p.ack = ak[k];
         p.tcode = tc[k];
         p.rt = 2'(k);
         p.dest_id = {10'h2a5 ^ 10'(k), 6'h13};
         p.tlabel = 6'(k * 9 + 5);
         p.src_id = {10'h155, 6'(k + 2)};
         p.offset_high = 16'h9abc ^ 16'(k);
         p.offset_low = 32'h1234_5670 + 32'(k * 16);
         p.prio = 4'h0;
         p.data = 32'hc0de_0000 | 32'(k);
         has = (tc[k] == `QR_TC_WR_QUAD) || (tc[k] == `QR_TC_RD_RESP_Q);
         e[0] = 32'h0;
         e[0][`QR_TK_PACKET_COMPLETE_FLAG_BIT] = `QR_PACKET_COMPLETE_FLAG_LAST;
         e[0][`QR_TK_SPD_HI:`QR_TK_SPD_LO] = p.spd;
         e[0][`QR_TK_CNT_HI:`QR_TK_CNT_LO] = has ? `QR_CNT_ONE : `QR_CNT_NONE;
         e[0][`QR_TK_TCODE_HI:`QR_TK_TCODE_LO] = p.tcode;
         e[0][`QR_TK_ACK_HI:`QR_TK_ACK_LO] = p.ack;
         e[1] = {p.dest_id.bus, p.dest_id.node, p.tlabel, p.rt, p.tcode, p.prio};
         e[2] = {p.src_id, (p.tcode == `QR_TC_LOCK_RESP) ?
                 (p.offset_high & `QR_RCODE_MASK) : p.offset_high};
         e[3] = p.offset_low;
         e[4] = has ? p.data : 32'h0;
         e[5] = 32'h0;
         send_pkt(p);
         bus(1'b0, `QR_OFS_STATUS, 32'h0, r);
         chk(r, {16'h0000, 8'(k + 1), 6'h00, 2'b11});
         for (int i = 0; i < 6; i++)
         begin
            repeat (gap[k]) @(posedge i_clk);
            bus(1'b0, `QR_OFS_RXFIFO, 32'h0, q[i]);
         end
         chk(q[0], e[0]);
         chk(q[1], e[1]);
         chk(q[2], e[2]);
         chk(q[3], e[3]);
         chk(q[4], e[4]);
         chk(q[5], e[5]);
      end
   endtask

   initial
   begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      reg_access();
      run_formats();
      summarize();
   end
endmodule
